// [include/long_decode_defs.svh]
// Constants for the four-byte opcode decoder and state-count model
`ifndef LONG_DECODE_DEFS_SVH
`define LONG_DECODE_DEFS_SVH

`define PFX_CTRL_LOAD     16'h0140
`define PFX_SMUL          16'h01c0
`define PFX_SDIV          16'h01d0
`define PFX_LOGIC         16'h01f0
`define PFX_BIT_REG_RD    8'h7c
`define PFX_BIT_REG_WR    8'h7d
`define PFX_BIT_ABS_RD    8'h7e
`define PFX_BIT_ABS_WR    8'h7f
`define THIRD_SUB_RD6     4'h6
`define THIRD_SUB_RD7     4'h7
`define INV_BIT_POS       7
`define ST_ONCHIP_MEM     4'h2
`define ST_INTERNAL       4'h1
`define ST_IO8            4'h6
`define ST_IO8_BYTE       4'h3
`define ST_IO16           4'h3
`define ST_EXT8_2_WORD    4'h4
`define ST_EXT8_2_BYTE    4'h2
`define ST_EXT8_3_WORD    4'h6
`define ST_EXT8_3_BYTE    4'h3
`define ST_EXT16_2        4'h2
`define ST_EXT16_3        4'h3

`endif

// [include/long_decode_pkg.sv]
// Types for the four-byte opcode decoder
package long_decode_pkg;

	typedef enum logic [4:0] {
		OP_NONE, OP_LOAD_CONTROL_REGISTER, OP_SIGNED_MULTIPLY_EXTEND,
		OP_SIGNED_DIVIDE_EXTEND, OP_LONG_OR, OP_LONG_XOR, OP_LONG_AND,
		OP_BIT_TEST, OP_BIT_OR, OP_INV_BIT_OR, OP_BIT_XOR, OP_INV_BIT_XOR,
		OP_BIT_AND, OP_INV_BIT_AND, OP_BIT_LOAD, OP_INV_BIT_LOAD,
		OP_BIT_STORE, OP_INV_BIT_STORE, OP_BIT_SET, OP_BIT_INVERT, OP_BIT_CLEAR
	} op_type;

	typedef enum logic [2:0] {
		AREA_ONCHIP_MEM, AREA_IO_8BIT, AREA_IO_16BIT,
		AREA_EXT8_2STATE, AREA_EXT8_3STATE, AREA_EXT16_2STATE, AREA_EXT16_3STATE
	} area_type;

	typedef struct packed {
		logic [7:0] first_byte;
		logic [7:0] second_byte;
		logic [7:0] third_byte;
		logic [7:0] fourth_byte;
	} code_type;

	typedef struct packed {
		op_type     op;
		logic       valid;
		logic       uses_reg;
		logic [2:0] addr_reg;
		logic       uses_abs;
		logic [7:0] abs_addr;
		logic [2:0] bit_num;
	} decode_type;

	typedef struct packed {
		logic [7:0] fetch;
		logic [7:0] branch_read;
		logic [7:0] stack;
		logic [7:0] byte_data;
		logic [7:0] word_data;
		logic [7:0] internal;
	} cycles_type;

	typedef struct packed {
		area_type fetch_area;
		area_type branch_area;
		area_type stack_area;
		area_type data_area;
		logic [3:0] waits;
	} areas_type;

endpackage : long_decode_pkg

// [design/long_decode.sv]
// Four-byte opcode decoder and execution state-count model
//
// How it works
// - fourth high nibble MSB 0 picks plain bit op
// - fourth high nibble MSB 1 picks inverted variant
// - register prefixes take register field as pointer
// - absolute prefixes take second byte as address
// - states equal sum of cycles times states
// - states per cycle follow bus width, access
// - fetch, data and internal cycles counted separately
`include "long_decode_defs.svh"

module long_decode
	import long_decode_pkg::*;
#(
	parameter int STATE_W = 16
) (
	input  wire logic               SYS_CLK_IN,
	input  wire logic               SRST_IN,
	input  wire code_type           CODE_IN,
	input  wire cycles_type         CYCLES_IN,
	input  wire areas_type          AREAS_IN,
	output decode_type              DECODE_OUT,
	output logic [STATE_W-1:0]      STATES_OUT
);

	if (STATE_W < 16) begin : g_state_w_check
		$error("STATE_W too small for the state sum");
	end

	// ----------------------------------------
	// Per-cycle state figures
	// ----------------------------------------
	function automatic logic [5:0] states_per(input area_type a, input logic is_word,
		input logic [3:0] m);
		logic [5:0] s;
		logic [5:0] w;
		w = 6'(m);
		s = 6'(`ST_ONCHIP_MEM);
		unique case (a)
			AREA_ONCHIP_MEM:   s = 6'(`ST_ONCHIP_MEM);
			AREA_IO_8BIT:      s = is_word ? 6'(`ST_IO8) : 6'(`ST_IO8_BYTE);
			AREA_IO_16BIT:     s = 6'(`ST_IO16);
			AREA_EXT8_2STATE:  s = is_word ? 6'(`ST_EXT8_2_WORD) : 6'(`ST_EXT8_2_BYTE);
			AREA_EXT8_3STATE:  s = is_word ? 6'(`ST_EXT8_3_WORD) + (w << 1)
			                               : 6'(`ST_EXT8_3_BYTE) + w;
			AREA_EXT16_2STATE: s = 6'(`ST_EXT16_2);
			AREA_EXT16_3STATE: s = 6'(`ST_EXT16_3) + w;
			default:           s = 6'(`ST_ONCHIP_MEM);
		endcase
		return s;
	endfunction : states_per

	function automatic logic [STATE_W-1:0] mul(input logic [7:0] c, input logic [5:0] s);
		return STATE_W'(c) * STATE_W'(s);
	endfunction : mul

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	decode_type dec_d;
	decode_type dec_q;
	logic       inv;
	logic [3:0] ch;

	always_comb begin
		dec_d          = '0;
		dec_d.op       = OP_NONE;
		inv            = CODE_IN.fourth_byte[`INV_BIT_POS];
		ch             = CODE_IN.third_byte[7:4];
		dec_d.bit_num  = CODE_IN.fourth_byte[6:4];
		if ({CODE_IN.first_byte, CODE_IN.second_byte} == `PFX_CTRL_LOAD) begin
			if (CODE_IN.third_byte[7:4] == 4'h6 && CODE_IN.third_byte[3]
				&& CODE_IN.third_byte[0]) begin
				dec_d.op = OP_LOAD_CONTROL_REGISTER;
			end
		end else if ({CODE_IN.first_byte, CODE_IN.second_byte} == `PFX_SMUL) begin
			if (CODE_IN.third_byte[7:4] == 4'h5 && CODE_IN.third_byte[3:2] == 2'h0
				&& !CODE_IN.third_byte[0]) begin
				dec_d.op = OP_SIGNED_MULTIPLY_EXTEND;
			end
		end else if ({CODE_IN.first_byte, CODE_IN.second_byte} == `PFX_SDIV) begin
			if (CODE_IN.third_byte[7:4] == 4'h5 && CODE_IN.third_byte[3:2] == 2'h0
				&& CODE_IN.third_byte[0]) begin
				dec_d.op = OP_SIGNED_DIVIDE_EXTEND;
			end
		end else if ({CODE_IN.first_byte, CODE_IN.second_byte} == `PFX_LOGIC) begin
			if (CODE_IN.third_byte[7:4] == 4'h6) begin
				unique case (CODE_IN.third_byte[3:0])
					4'h4:    dec_d.op = OP_LONG_OR;
					4'h5:    dec_d.op = OP_LONG_XOR;
					4'h6:    dec_d.op = OP_LONG_AND;
					default: dec_d.op = OP_NONE;
				endcase
			end
		end else if (CODE_IN.first_byte[7:2] == 6'(`PFX_BIT_REG_RD >> 2)
			&& (CODE_IN.first_byte[1] || CODE_IN.second_byte[3:0] == 4'h0)) begin
			if (!CODE_IN.first_byte[1]) begin
				dec_d.uses_reg = 1'b1;
				dec_d.addr_reg = CODE_IN.second_byte[6:4];
			end else begin
				dec_d.uses_abs = 1'b1;
				dec_d.abs_addr = CODE_IN.second_byte;
			end
			if (!CODE_IN.first_byte[0]) begin
				unique case ({ch == `THIRD_SUB_RD7, CODE_IN.third_byte[3:0]})
					5'h03, 5'h13: dec_d.op = OP_BIT_TEST;
					5'h14: dec_d.op = inv ? OP_INV_BIT_OR  : OP_BIT_OR;
					5'h15: dec_d.op = inv ? OP_INV_BIT_XOR : OP_BIT_XOR;
					5'h16: dec_d.op = inv ? OP_INV_BIT_AND : OP_BIT_AND;
					5'h17: dec_d.op = inv ? OP_INV_BIT_LOAD : OP_BIT_LOAD;
					default: dec_d.op = OP_NONE;
				endcase
			end else begin
				unique case (CODE_IN.third_byte[3:0])
					4'h0: dec_d.op = OP_BIT_SET;
					4'h1: dec_d.op = OP_BIT_INVERT;
					4'h2: dec_d.op = OP_BIT_CLEAR;
					4'h7: dec_d.op = (ch == `THIRD_SUB_RD6)
						? (inv ? OP_INV_BIT_STORE : OP_BIT_STORE) : OP_NONE;
					default: dec_d.op = OP_NONE;
				endcase
			end
			if (ch != `THIRD_SUB_RD6 && ch != `THIRD_SUB_RD7) dec_d.op = OP_NONE;
		end
		dec_d.valid = (dec_d.op != OP_NONE);
	end

	// ----------------------------------------
	// State count
	// ----------------------------------------
	logic [STATE_W-1:0] states_d;
	logic [STATE_W-1:0] states_q;

	always_comb begin
		states_d = mul(CYCLES_IN.fetch,
				states_per(AREAS_IN.fetch_area, 1'b1, AREAS_IN.waits))
			+ mul(CYCLES_IN.branch_read,
				states_per(AREAS_IN.branch_area, 1'b1, AREAS_IN.waits))
			+ mul(CYCLES_IN.stack,
				states_per(AREAS_IN.stack_area, 1'b1, AREAS_IN.waits))
			+ mul(CYCLES_IN.byte_data,
				states_per(AREAS_IN.data_area, 1'b0, AREAS_IN.waits))
			+ mul(CYCLES_IN.word_data,
				states_per(AREAS_IN.data_area, 1'b1, AREAS_IN.waits))
			+ mul(CYCLES_IN.internal, 6'(`ST_INTERNAL));
	end

	always_ff @(posedge SYS_CLK_IN) begin
		if (SRST_IN) begin
			dec_q    <= '0;
			states_q <= '0;
		end else begin
			dec_q    <= dec_d;
			states_q <= states_d;
		end
	end

	assign DECODE_OUT = dec_q;
	assign STATES_OUT = states_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_plain_bit_load: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		(CODE_IN.first_byte == 8'h7c && CODE_IN.third_byte == 8'h77
		&& CODE_IN.second_byte[3:0] == 4'h0 && !CODE_IN.fourth_byte[7])
		|=> DECODE_OUT.op == OP_BIT_LOAD)
		else $error("plain bit load not selected");
	a_inv_bit_load: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		(CODE_IN.first_byte == 8'h7c && CODE_IN.third_byte == 8'h77
		&& CODE_IN.second_byte[3:0] == 4'h0 && CODE_IN.fourth_byte[7])
		|=> DECODE_OUT.op == OP_INV_BIT_LOAD)
		else $error("inverted bit load not selected");
	a_reg_field_taken: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		(CODE_IN.first_byte == 8'h7d && CODE_IN.second_byte[3:0] == 4'h0)
		|=> DECODE_OUT.uses_reg && DECODE_OUT.addr_reg == $past(CODE_IN.second_byte[6:4]))
		else $error("register field not taken");
	a_abs_addr_taken: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		(CODE_IN.first_byte == 8'h7f && CODE_IN.second_byte[3:0] == 4'h0)
		|=> DECODE_OUT.uses_abs && DECODE_OUT.abs_addr == $past(CODE_IN.second_byte))
		else $error("absolute address not taken");
	a_onchip_sum: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		(AREAS_IN.fetch_area == AREA_ONCHIP_MEM && CYCLES_IN.branch_read == 8'h00
		&& CYCLES_IN.stack == 8'h00 && CYCLES_IN.byte_data == 8'h00
		&& CYCLES_IN.word_data == 8'h00)
		|=> STATES_OUT == STATE_W'(2 * $past(CYCLES_IN.fetch) + $past(CYCLES_IN.internal)))
		else $error("state sum wrong");
	a_io8_byte: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		(AREAS_IN.data_area == AREA_IO_8BIT && CYCLES_IN.fetch == 8'h00
		&& CYCLES_IN.branch_read == 8'h00 && CYCLES_IN.stack == 8'h00
		&& CYCLES_IN.word_data == 8'h00 && CYCLES_IN.internal == 8'h00)
		|=> STATES_OUT == STATE_W'(3 * $past(CYCLES_IN.byte_data)))
		else $error("byte access states wrong");
	a_internal_only: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		(CYCLES_IN.fetch == 8'h00 && CYCLES_IN.branch_read == 8'h00
		&& CYCLES_IN.stack == 8'h00 && CYCLES_IN.byte_data == 8'h00
		&& CYCLES_IN.word_data == 8'h00)
		|=> STATES_OUT == STATE_W'($past(CYCLES_IN.internal)))
		else $error("internal cycles miscounted");
	a_smul_map: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		({CODE_IN.first_byte, CODE_IN.second_byte} == 16'h01c0
		&& CODE_IN.third_byte[7:4] == 4'h5 && CODE_IN.third_byte[3:2] == 2'h0
		&& !CODE_IN.third_byte[0])
		|=> DECODE_OUT.op == OP_SIGNED_MULTIPLY_EXTEND && DECODE_OUT.valid)
		else $error("signed multiply not mapped");
	a_ldc_odd_column: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		({CODE_IN.first_byte, CODE_IN.second_byte} == `PFX_CTRL_LOAD
		&& CODE_IN.third_byte[7:4] == 4'h6 && CODE_IN.third_byte[3]
		&& CODE_IN.third_byte[0])
		|=> DECODE_OUT.op == OP_LOAD_CONTROL_REGISTER)
		else $error("control register load not mapped");
	a_long_or_map: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		({CODE_IN.first_byte, CODE_IN.second_byte} == `PFX_LOGIC
		&& CODE_IN.third_byte == 8'h64)
		|=> DECODE_OUT.op == OP_LONG_OR)
		else $error("long or not mapped");
	a_inv_bit_store: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		(CODE_IN.first_byte == 8'h7d && CODE_IN.third_byte == 8'h67
		&& CODE_IN.second_byte[3:0] == 4'h0 && CODE_IN.fourth_byte[7])
		|=> DECODE_OUT.op == OP_INV_BIT_STORE)
		else $error("inverted bit store not selected");
	a_abs_any_addr: assert property (@(posedge SYS_CLK_IN) disable iff (SRST_IN)
		(CODE_IN.first_byte == 8'h7e && CODE_IN.third_byte == 8'h73)
		|=> DECODE_OUT.op == OP_BIT_TEST
		&& DECODE_OUT.abs_addr == $past(CODE_IN.second_byte))
		else $error("absolute bit test address not taken");

endmodule : long_decode

// [test/code_rom.sv]
// Program memory model that hands whole four-byte codes to the decoder
module code_rom
	import long_decode_pkg::*;
(
	input  wire logic [4:0] idx_in,
	output code_type        code_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// ----------------------------------------
	// Code table
	// ----------------------------------------
	localparam logic [31:0] WORDS [32] = '{
		32'h7c307780, 32'h7c307700, 32'h7d506780, 32'h7d506700,
		32'h7ea07480, 32'h7ea07400, 32'h01c05000, 32'h01d05100,
		32'h01f06400, 32'h01f06500, 32'h01f06600, 32'h01406900,
		32'hffffffff, 32'h7fa06780, 32'h7ec57330, 32'h7c206350,
		32'h7c607580, 32'h7e3f7500, 32'h7c107680, 32'h7e017600,
		32'h7d707000, 32'h7fff6110, 32'h7d407220, 32'h7d407780,
		32'h7c306400, 32'h01c05400, 32'h01406800, 32'hffffffff,
		32'hffffffff, 32'hffffffff, 32'hffffffff, 32'hffffffff
	};

	assign code_out = code_type'(WORDS[idx_in]);

endmodule : code_rom

// [test/tb.sv]
// Self-checking bench for the four-byte decoder and state-count model
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import long_decode_pkg::*;

	logic        clk;
	logic        srst;
	logic [4:0]  idx;
	code_type    code;
	cycles_type  cyc;
	areas_type   areas;
	decode_type  dec;
	logic [15:0] states;
	int          fails;
	int          samples_checked;

	// ----------------------------------------
	// Clock, memory model and decoder
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	code_rom rom (.idx_in(idx), .code_out(code));

	long_decode #(.STATE_W(16)) dut (
		.SYS_CLK_IN(clk), .SRST_IN(srst), .CODE_IN(code), .CYCLES_IN(cyc),
		.AREAS_IN(areas), .DECODE_OUT(dec), .STATES_OUT(states)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic step();
		@(posedge clk);
		#2;
	endtask : step

	task automatic check_bit(input logic [4:0] i, input op_type op, input logic ureg,
			input logic [7:0] where);
		idx = i;
		step();
		chk("op", 32'(op), 32'(dec.op));
		chk("valid", 32'h1, 32'(dec.valid));
		chk("uses_reg", 32'(ureg), 32'(dec.uses_reg));
		chk("uses_abs", 32'(!ureg), 32'(dec.uses_abs));
		if (ureg) chk("addr_reg", 32'(where[2:0]), 32'(dec.addr_reg));
		else chk("abs_addr", 32'(where), 32'(dec.abs_addr));
	endtask : check_bit

	task automatic states_case(input cycles_type c, input areas_type a, input logic [15:0] exp);
		cyc = c;
		areas = a;
		step();
		chk("states", 32'(exp), 32'(states));
	endtask : states_case

	task print_verdict();
		if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic reset_clears();
		chk("op_in_reset", 32'(OP_NONE), 32'(dec.op));
		chk("states_in_reset", 32'h0, 32'(states));
	endtask : reset_clears

	task automatic register_pointer_pairs();
		check_bit(5'h00, OP_INV_BIT_LOAD, 1'b1, 8'h03);
		check_bit(5'h01, OP_BIT_LOAD, 1'b1, 8'h03);
		check_bit(5'h02, OP_INV_BIT_STORE, 1'b1, 8'h05);
		check_bit(5'h03, OP_BIT_STORE, 1'b1, 8'h05);
	endtask : register_pointer_pairs

	task automatic absolute_pairs();
		check_bit(5'h04, OP_INV_BIT_OR, 1'b0, 8'ha0);
		check_bit(5'h05, OP_BIT_OR, 1'b0, 8'ha0);
		check_bit(5'h0d, OP_INV_BIT_STORE, 1'b0, 8'ha0);
	endtask : absolute_pairs

	task automatic more_bit_ops();
		check_bit(5'h0e, OP_BIT_TEST, 1'b0, 8'hc5);
		chk("bit_num", 32'h3, 32'(dec.bit_num));
		check_bit(5'h0f, OP_BIT_TEST, 1'b1, 8'h02);
		check_bit(5'h10, OP_INV_BIT_XOR, 1'b1, 8'h06);
		check_bit(5'h11, OP_BIT_XOR, 1'b0, 8'h3f);
		check_bit(5'h12, OP_INV_BIT_AND, 1'b1, 8'h01);
		check_bit(5'h13, OP_BIT_AND, 1'b0, 8'h01);
		check_bit(5'h14, OP_BIT_SET, 1'b1, 8'h07);
		check_bit(5'h15, OP_BIT_INVERT, 1'b0, 8'hff);
		chk("bit_num", 32'h1, 32'(dec.bit_num));
		check_bit(5'h16, OP_BIT_CLEAR, 1'b1, 8'h04);
		chk("bit_num", 32'h2, 32'(dec.bit_num));
	endtask : more_bit_ops

	task automatic refused_codes();
		logic [4:0] bad [4] = '{5'h17, 5'h18, 5'h19, 5'h1a};
		for (int j = 0; j < 4; j++) begin
			idx = bad[j];
			step();
			chk("refused_op", 32'(OP_NONE), 32'(dec.op));
			chk("refused_valid", 32'h0, 32'(dec.valid));
		end
	endtask : refused_codes

	task automatic prefix_map();
		op_type ops [7] = '{OP_SIGNED_MULTIPLY_EXTEND, OP_SIGNED_DIVIDE_EXTEND, OP_LONG_OR,
			OP_LONG_XOR, OP_LONG_AND, OP_LOAD_CONTROL_REGISTER, OP_NONE};
		for (int j = 0; j < 7; j++) begin
			idx = 5'(j + 6);
			step();
			chk("prefix_op", 32'(ops[j]), 32'(dec.op));
			chk("prefix_valid", 32'(ops[j] != OP_NONE), 32'(dec.valid));
		end
	endtask : prefix_map

	task automatic state_sums();
		states_case('{8'h02, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00}, '{AREA_EXT16_3STATE,
			AREA_EXT16_3STATE, AREA_EXT16_3STATE, AREA_IO_8BIT, 4'h1}, 16'h000e);
		states_case('{8'h02, 8'h02, 8'h02, 8'h00, 8'h00, 8'h00}, '{AREA_EXT16_3STATE,
			AREA_EXT16_3STATE, AREA_EXT16_3STATE, AREA_IO_8BIT, 4'h1}, 16'h0018);
		states_case('{8'h03, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04}, '{AREA_ONCHIP_MEM,
			AREA_ONCHIP_MEM, AREA_ONCHIP_MEM, AREA_ONCHIP_MEM, 4'h0}, 16'h000a);
		states_case('{8'h01, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00}, '{AREA_EXT8_3STATE,
			AREA_EXT8_3STATE, AREA_EXT8_3STATE, AREA_EXT8_3STATE, 4'h1}, 16'h0014);
		states_case('{8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00}, '{AREA_IO_16BIT,
			AREA_EXT16_2STATE, AREA_IO_8BIT, AREA_EXT8_2STATE, 4'h0}, 16'h0011);
		states_case('{8'h00, 8'h00, 8'h00, 8'h05, 8'h00, 8'h00}, '{AREA_ONCHIP_MEM,
			AREA_ONCHIP_MEM, AREA_ONCHIP_MEM, AREA_IO_8BIT, 4'h0}, 16'h000f);
		states_case('{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h07}, '{AREA_ONCHIP_MEM,
			AREA_ONCHIP_MEM, AREA_ONCHIP_MEM, AREA_ONCHIP_MEM, 4'h0}, 16'h0007);
		states_case('{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00}, '{AREA_ONCHIP_MEM,
			AREA_ONCHIP_MEM, AREA_ONCHIP_MEM, AREA_EXT8_3STATE, 4'hf}, 16'h23dc);
	endtask : state_sums

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		fails = 0;
		samples_checked = 0;
		idx = 5'h00;
		cyc = '0;
		areas = '0;
		srst = 1'b1;
		repeat (16) @(posedge clk);
		#2;
		reset_clears();
		srst = 1'b0;
		register_pointer_pairs();
		absolute_pairs();
		more_bit_ops();
		refused_codes();
		prefix_map();
		state_sums();
		srst = 1'b1;
		step();
		reset_clears();
		srst = 1'b0;
		check_bit(5'h00, OP_INV_BIT_LOAD, 1'b1, 8'h03);
		print_verdict();
	end

	initial begin
		#200us;
		fails++;
		print_verdict();
	end

endmodule : tb
